// *** rtl/format_detector_pkg.sv ***
package format_detector_pkg;

    // Timing reference words
    localparam logic [9:0] TRS_ONES  = 10'h3ff;
    localparam logic [9:0] TRS_ZEROS = 10'h000;
    // Flags word bit positions
    localparam int FLAG_H_BIT = 6;
    localparam int FLAG_V_BIT = 7;

    localparam int WORD_W  = 13;
    localparam int LINE_W  = 11;
    localparam int CODE_W  = 4;
    localparam int NUM_FMT = 16;

    // Register map
    localparam logic [11:0] REG_CONTROL = 12'h000;
    localparam logic [11:0] REG_STATUS  = 12'h004;
    localparam logic [11:0] REG_COUNTS  = 12'h008;
    localparam logic [11:0] REG_LINE    = 12'h00c;
    localparam logic [11:0] REG_TABLE   = 12'h100;
    localparam int CTRL_REACQ_BIT = 0;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    localparam int DEFAULT_ERROR_LIMIT = 4;

    typedef enum logic [9:0] {
        ACQ_START   = 10'b00_0000_0001,
        ACQ_WAIT    = 10'b00_0000_0010,
        ACQ_COUNT   = 10'b00_0000_0100,
        ACQ_LINES   = 10'b00_0000_1000,
        FMT_COMPARE = 10'b00_0001_0000,
        LCK_WAIT    = 10'b00_0010_0000,
        LCK_COUNT   = 10'b00_0100_0000,
        LCK_LINES   = 10'b00_1000_0000,
        LCK_COMPARE = 10'b01_0000_0000,
        LCK_ERROR   = 10'b10_0000_0000
    } detect_state_e;

endpackage

// *** rtl/format_detector.sv ***
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
// Behaviour
// (R1) After reset the machine starts in the acquisition loop.
// (R2) Acquiring, counting starts at a start-of-active flags word on first active line.
// (R3) Word counter advances every cycle, line counter once per line.
// (R4) Word counting stops at the next start-of-active flags word.
// (R5) Line counting continues until the vertical flag rises.
// (R6) Format index is zero on entering comparison and addresses the tables.
// (R7) Comparison steps the index once per cycle until match or terminal count.
// (R8) On match the index is stored as format code, then locked loop.
// (R9) No match by terminal count returns to the acquisition start.
// (R10) Locked, measure and compare counts with the locked format.
// (R11) Locked mismatch passes an error state and increments the error counter.
// (R12) Error counter at the limit returns to acquisition.
// (R13) A locked match clears the error counter.
// (R14) Reacquire high forces the acquisition start state.
// (R15) Segmented look-alikes may report the interlaced code.
// (R16) Detected format is a four-bit code.
// (R17) Locked, first active line loads line number from per-format table.
// (R18) Line number advances per end-of-active marker, reloads 1 after maximum.
// (R19) Markers are one all-ones word then two all-zeros words, then flags.
// (R20) Error limit is a parameter; code valid only while locked.
module format_detector
    import format_detector_pkg::*;
#(
    parameter int ERROR_LIMIT = DEFAULT_ERROR_LIMIT
) (
    // Clock and reset
    input  wire logic                sys_clk,
    input  wire logic                rstn,
    // Video stream, one channel word per clock
    input  wire logic [9:0]          video_word,
    input  wire logic                reacquire,
    // Detection results
    output logic [CODE_W-1:0]        format_code,
    output logic                     format_locked,
    output logic [LINE_W-1:0]        line_number,
    // AXI4-Lite write address
    input  wire logic [11:0]         s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [11:0]         s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready
);

    logic                 rst_s1;
    logic                 rst_n;
    logic [9:0]           w1;
    logic [9:0]           w2;
    logic [9:0]           w3;
    logic                 v_prev;
    detect_state_e        state;
    detect_state_e        next_state;
    logic [WORD_W-1:0]    word_cnt;
    logic [LINE_W-1:0]    line_cnt;
    logic [CODE_W-1:0]    fmt_index;
    logic [7:0]           err_cnt;
    logic                 soft_reacq;
    logic [WORD_W-1:0]    tbl_words [NUM_FMT];
    logic [LINE_W-1:0]    tbl_lines [NUM_FMT];
    logic [LINE_W-1:0]    tbl_first [NUM_FMT];
    logic [LINE_W-1:0]    tbl_max   [NUM_FMT];

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    // (R19) Preamble then flags word
    wire trs_flags = (w3 == TRS_ONES) && (w2 == TRS_ZEROS) && (w1 == TRS_ZEROS);
    wire flag_v    = video_word[FLAG_V_BIT];
    wire sav       = trs_flags && !video_word[FLAG_H_BIT];
    wire eav       = trs_flags && video_word[FLAG_H_BIT];
    wire first_act = sav && v_prev && !flag_v;
    wire v_rise    = eav && !v_prev && flag_v;
    wire [CODE_W-1:0] cmp_index = (state == LCK_COMPARE) ? format_code : fmt_index;
    // (R15) Look-alikes compare equal; first table hit is reported
    wire table_hit = (tbl_words[cmp_index] == word_cnt) && (tbl_lines[cmp_index] == line_cnt);
    wire index_end = (fmt_index == CODE_W'(NUM_FMT - 1));
    wire err_full  = (err_cnt >= 8'(ERROR_LIMIT - 1));

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            w1     <= 10'h000;
            w2     <= 10'h000;
            w3     <= 10'h000;
            // Low until a blank line is seen, so a mid-field join starts no count
            v_prev <= 1'b0;
        end else begin
            w1 <= video_word;
            w2 <= w1;
            w3 <= w2;
            // V of the previous line, so the active line's own EAV cannot hide the fall
            if (sav)
                v_prev <= flag_v;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            ACQ_START:   next_state = ACQ_WAIT;
            // (R2) Start at first active line
            ACQ_WAIT:    if (first_act) next_state = ACQ_COUNT;
            // (R4) Stop words at next active start
            ACQ_COUNT:   if (sav) next_state = ACQ_LINES;
            // (R5) Lines end at blanking
            ACQ_LINES:   if (v_rise) next_state = FMT_COMPARE;
            FMT_COMPARE: begin
                // (R8) Match enters lock
                if (table_hit)
                    next_state = LCK_WAIT;
                // (R9) Exhausted, restart
                else if (index_end)
                    next_state = ACQ_START;
            end
            // (R10) Locked measurement loop
            LCK_WAIT:    if (first_act) next_state = LCK_COUNT;
            LCK_COUNT:   if (sav) next_state = LCK_LINES;
            LCK_LINES:   if (v_rise) next_state = LCK_COMPARE;
            LCK_COMPARE: next_state = table_hit ? LCK_WAIT : LCK_ERROR;
            // (R12) Too many errors
            LCK_ERROR:   next_state = err_full ? ACQ_START : LCK_WAIT;
            default:     next_state = ACQ_START;
        endcase
        // (R14) Forced reacquire
        if (reacquire || soft_reacq)
            next_state = ACQ_START;
    end

    wire counting = (state == ACQ_COUNT) || (state == LCK_COUNT);
    wire lining   = counting || (state == ACQ_LINES) || (state == LCK_LINES);
    wire start_c  = (state == ACQ_WAIT || state == LCK_WAIT) && first_act;

    // (R1) Reset into acquisition
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            state <= ACQ_START;
        else
            state <= next_state;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            word_cnt <= '0;
            line_cnt <= '0;
        end else if (start_c) begin
            word_cnt <= WORD_W'(1);
            line_cnt <= LINE_W'(1);
        end else begin
            // (R3) Words per cycle, lines per line
            if (counting && !sav)
                word_cnt <= word_cnt + WORD_W'(1);
            if (lining && eav && !flag_v)
                line_cnt <= line_cnt + LINE_W'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            fmt_index <= '0;
        // (R7) Step index in comparison
        else if (state == FMT_COMPARE && !table_hit && !index_end)
            fmt_index <= fmt_index + CODE_W'(1);
        // (R6) Zero on entry
        else if (state != FMT_COMPARE)
            fmt_index <= '0;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            format_code   <= '0;
            format_locked <= 1'b0;
            err_cnt       <= '0;
        end else begin
            // (R8) (R16) Store four-bit code
            if (state == FMT_COMPARE && table_hit)
                format_code <= fmt_index;
            // (R20) Valid only in locked loop
            format_locked <= (next_state == LCK_WAIT) || (next_state == LCK_COUNT) ||
                             (next_state == LCK_LINES) || (next_state == LCK_COMPARE) ||
                             (next_state == LCK_ERROR);
            // (R13) Match clears errors
            if (state == LCK_COMPARE && table_hit)
                err_cnt <= '0;
            // (R11) Count mismatch
            else if (state == LCK_ERROR)
                err_cnt <= err_cnt + 8'h01;
            else if (!format_locked)
                err_cnt <= '0;
        end
    end

    wire at_max = (line_number >= tbl_max[format_code]);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            line_number <= LINE_W'(1);
        else if (format_locked) begin
            // (R17) Load first active line
            if (eav && v_prev && !flag_v)
                line_number <= tbl_first[format_code];
            // (R18) Advance or roll to one
            else if (eav)
                line_number <= at_max ? LINE_W'(1) : line_number + LINE_W'(1);
        end
    end

    // Register bus slave
    logic [11:0] aw_addr;
    logic        aw_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        w_held;
    wire         do_write  = aw_held && w_held && !s_axi_bvalid;
    wire         w_control = (aw_addr == REG_CONTROL);
    wire         w_tbl     = aw_addr[11:8] == REG_TABLE[11:8] && aw_addr[7:6] == 2'b00;
    wire [3:0]   w_tidx    = aw_addr[5:2];
    wire [3:0]   r_tidx    = s_axi_araddr[5:2];
    wire         r_tbl     = s_axi_araddr[11:8] == REG_TABLE[11:8] && s_axi_araddr[7:6] == 2'b00;
    wire         rd_take   = s_axi_arvalid && s_axi_arready;
    wire         next_aw_held = (aw_held || (s_axi_awvalid && s_axi_awready)) && !do_write;
    wire         next_w_held  = (w_held || (s_axi_wvalid && s_axi_wready)) && !do_write;
    wire         next_bvalid  = do_write || (s_axi_bvalid && !s_axi_bready);
    wire         next_rvalid  = rd_take || (s_axi_rvalid && !s_axi_rready);

    // Ready flags registered from next-cycle occupancy
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_awready <= !next_aw_held && !next_bvalid;
            s_axi_wready  <= !next_w_held && !next_bvalid;
            s_axi_arready <= !next_rvalid;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_addr      <= '0;
            aw_held      <= 1'b0;
            w_data       <= '0;
            w_strb       <= '0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
            soft_reacq   <= 1'b0;
        end else begin
            soft_reacq <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
                aw_held <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                w_held <= 1'b1;
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (w_control || w_tbl) ? RESP_OKAY : RESP_SLVERR;
                if (w_control && w_strb[0])
                    soft_reacq <= w_data[CTRL_REACQ_BIT];
            end else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Format tables, loaded by software: words[12:0], lines[26:16]
    always_ff @(posedge sys_clk) begin
        if (do_write && w_tbl && w_strb == 4'hf) begin
            tbl_words[w_tidx] <= w_data[WORD_W-1:0];
            tbl_lines[w_tidx] <= w_data[16 +: LINE_W];
        end
        if (do_write && aw_addr[11:8] == REG_TABLE[11:8] && aw_addr[7:6] == 2'b01
            && w_strb == 4'hf) begin
            tbl_first[w_tidx] <= w_data[LINE_W-1:0];
            tbl_max[w_tidx]   <= w_data[16 +: LINE_W];
        end
    end

    wire r_tbl2 = s_axi_araddr[11:8] == REG_TABLE[11:8] && s_axi_araddr[7:6] == 2'b01;
    wire [31:0] rd_mux =
        (s_axi_araddr == REG_CONTROL) ? 32'h0000_0000 :
        (s_axi_araddr == REG_STATUS)  ? {16'h0000, err_cnt, 3'b000, format_locked, format_code} :
        (s_axi_araddr == REG_COUNTS)  ? {5'h00, line_cnt, 3'b000, word_cnt} :
        (s_axi_araddr == REG_LINE)    ? {21'h000000, line_number} :
        r_tbl  ? {5'h00, tbl_lines[r_tidx], 3'b000, tbl_words[r_tidx]} :
        r_tbl2 ? {5'h00, tbl_max[r_tidx], 5'h00, tbl_first[r_tidx]} : 32'h0000_0000;
    wire rd_ok = (s_axi_araddr == REG_CONTROL) || (s_axi_araddr == REG_STATUS) ||
                 (s_axi_araddr == REG_COUNTS) || (s_axi_araddr == REG_LINE) || r_tbl || r_tbl2;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

endmodule

// *** test/format_detector_props.sv ***
`timescale 1ns/10ps
module format_detector_props
    import format_detector_pkg::*;
(
    // Clock, reset, control
    input wire logic              sys_clk,
    input wire logic              rstn,
    input wire logic              reacquire,
    // Results
    input wire logic [CODE_W-1:0] format_code,
    input wire logic              format_locked,
    input wire logic [LINE_W-1:0] line_number,
    // Register bus
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic [31:0]       s_axi_rdata
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence stays_unlocked;
        !format_locked [*8];
    endsequence
    AST_RESET_OUTS: assert property (disable iff (1'b0)
        !rstn [*2] |-> !format_locked && line_number == 11'h001) else $error("reset outputs wrong");
    AST_REACQ_DROP: assert property (reacquire |-> ##[1:2] !format_locked)
        else $error("reacquire did not unlock");
    AST_CODE_STEADY: assert property (format_locked && $past(format_locked)
        |-> format_code == $past(format_code)) else $error("code moved while locked");
    AST_RELOCK_SLOW: assert property ($fell(format_locked) |=> stays_unlocked)
        else $error("relocked without measuring");
    AST_LINE_NONZERO: assert property (line_number != 11'h000)
        else $error("line number zero");
    AST_B_ANSWER: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    AST_ONE_WRITE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
endmodule
bind format_detector format_detector_props u_format_detector_props (.sys_clk, .rstn,
    .reacquire, .format_code, .format_locked, .line_number, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

// *** test/video_source.sv ***
`timescale 1ns/10ps
module video_source (
    // Clock and control
    input wire logic        sys_clk,
    input wire logic        run,
    input wire logic [12:0] line_len,
    input wire logic [10:0] act_lines,
    // Stream
    output logic [9:0]      video_word
);
    localparam int BLANK = 3;
    logic [12:0] w  = '0;
    logic [10:0] ln = '0;
    logic        v;
    logic        h;
    assign v = ln < 11'(BLANK);
    assign h = w < 13'd4;
    always_comb begin
        if (!run || w >= 13'd8)
            video_word = {2'b01, w[7:0]};
        else if (w[1:0] == 2'd0)
            video_word = 10'h3ff;
        else if (w[1:0] == 2'd3)
            video_word = {2'b10, v, h, 6'h00};
        else
            video_word = 10'h000;
    end
    // Blank lines then active lines
    always_ff @(posedge sys_clk) begin
        if (w >= line_len - 13'd1) begin
            w  <= '0;
            ln <= (ln >= 11'(BLANK) + act_lines - 11'd1) ? '0 : ln + 11'd1;
        end else
            w <= w + 13'd1;
    end
endmodule

// *** test/format_detector_test.sv ***
`timescale 1ns/10ps
module format_detector_test
    import format_detector_pkg::*;
;
    localparam logic [31:0] GOOD = {5'h0, 11'd6, 3'h0, 13'd32};
    logic        sys_clk, rstn, reacquire, run, format_locked;
    logic [9:0]  video_word;
    logic [12:0] line_len;
    logic [10:0] act_lines, line_number;
    logic [3:0]  format_code, s_axi_wstrb;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int          error_cnt, tests_run, n;
    format_detector #(.ERROR_LIMIT(3)) u_format_detector (.sys_clk, .rstn, .video_word,
        .reacquire, .format_code, .format_locked, .line_number, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    video_source u_video_source (.sys_clk, .run, .line_len, .act_lines, .video_word);
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] wd, output logic [1:0] rs);
        @(posedge sys_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= wd;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        rs = s_axi_bresp;
    endtask
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] rd, output logic [1:0] rs);
        @(posedge sys_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        rs = s_axi_rresp;
    endtask
    task automatic chk_status(input logic [7:0] e, input logic l, input logic [3:0] c);
        axi_rd(REG_STATUS, d, r);
        chk("status", {16'h0, e, 3'h0, l, c}, d);
    endtask
    task automatic wait_lock(input logic want);
        n = 0;
        while (format_locked !== want && n < 3000) begin
            @(posedge sys_clk);
            n++;
        end
        chk("format_locked", 32'(want), 32'(format_locked));
    endtask
    task automatic print_verdict;
        if (error_cnt == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (40000) @(posedge sys_clk);
        error_cnt++;
        print_verdict();
    end
    initial begin
        {error_cnt, tests_run, rstn, reacquire, run, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hf;
        line_len = 13'd32;
        act_lines = 11'd6;
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk("line_number", 1, 32'(line_number));
        chk_status(8'h00, 1'b0, 4'h0);
        axi_rd(12'h200, d, r);
        chk("unmapped read", {30'h0, RESP_SLVERR}, {d[29:0], r});
        axi_wr(12'h204, 32'h1, r);
        chk("unmapped write", 32'(RESP_SLVERR), 32'(r));
        for (int i = 0; i < NUM_FMT; i++) begin
            axi_wr(REG_TABLE + 12'(4 * i), (i == 9 || i == 12) ? GOOD :
                {5'h0, 11'(i + 1), 3'h0, 13'(i + 40)}, r);
            axi_wr(REG_TABLE + 12'h040 + 12'(4 * i), {5'h0, 11'd9, 5'h0, 11'd4}, r);
        end
        axi_rd(REG_TABLE + 12'h024, d, r);
        chk("table entry", GOOD, d);
        run <= 1'b1;
        wait_lock(1'b1);
        chk("format_code", 9, 32'(format_code));
        axi_rd(REG_COUNTS, d, r);
        chk("counts", GOOD, d);
        d = 0;
        repeat (300) begin
            @(posedge sys_clk);
            if (line_number > d[10:0]) d = 32'(line_number);
        end
        chk("line max", 9, d);
        line_len <= 13'd40;
        d = 0;
        n = 0;
        while (d[15:8] == 8'h00 && n < 400) begin
            axi_rd(REG_STATUS, d, r);
            n++;
        end
        chk("first error", 32'h039, {19'h0, d[15:8], d[4:0]});
        line_len <= 13'd32;
        repeat (900) @(posedge sys_clk);
        chk_status(8'h00, 1'b1, 4'h9);
        line_len <= 13'd40;
        wait_lock(1'b0);
        repeat (1200) @(posedge sys_clk);
        chk("no match", 0, 32'(format_locked));
        line_len <= 13'd32;
        wait_lock(1'b1);
        reacquire <= 1'b1;
        @(posedge sys_clk);
        reacquire <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk("reacquire pin", 0, 32'(format_locked));
        wait_lock(1'b1);
        axi_wr(REG_CONTROL, 32'h1, r);
        repeat (3) @(posedge sys_clk);
        chk("reacquire reg", {30'h0, RESP_OKAY}, {31'(r), format_locked});
        wait_lock(1'b1);
        print_verdict();
    end
endmodule
